// >>> common/lss_pkg.sv
// Shared constants and carriers of the split-screen and panel power block.
// Assumes an 8-bit register port and a same-clock refresh timing source.
`default_nettype none

package lss_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] LSS_OFF_MODE2 = 8'h03;
    localparam logic [7:0] LSS_OFF_S1_LO = 8'h0C;
    localparam logic [7:0] LSS_OFF_S1_MID = 8'h0D;
    localparam logic [7:0] LSS_OFF_S2_LO = 8'h0E;
    localparam logic [7:0] LSS_OFF_S2_MID = 8'h0F;
    localparam logic [7:0] LSS_OFF_HI_BITS = 8'h10;
    localparam logic [7:0] LSS_OFF_LINES_LO = 8'h12;
    localparam logic [7:0] LSS_OFF_LINES_HI = 8'h13;
    localparam logic [7:0] LSS_OFF_PORTRAIT = 8'h1B;
    localparam logic [7:0] LSS_OFF_PANEL_LO = 8'h30;
    localparam logic [7:0] LSS_OFF_PANEL_HI = 8'h31;
    localparam logic [7:0] LSS_OFF_STATUS = 8'h32;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int LSS_BIT_OVERRIDE = 3;
    localparam int LSS_BIT_HW_EN = 7;
    localparam int LSS_BIT_S1_B16 = 0;
    localparam int LSS_BIT_S2_B16 = 1;
    localparam int LSS_BIT_PORTRAIT = 7;
    localparam logic [1:0] LSS_SWPS_NORMAL = 2'h3;
    localparam logic [1:0] LSS_SWPS_SAVE = 2'h0;

    // ----------------------------------------
    // Reset values and frame counts
    // ----------------------------------------
    localparam logic [7:0] LSS_RST_BYTE = 8'h00;
    localparam logic [7:0] LSS_DISCHARGE_FRAMES = 8'h80;
    localparam logic [9:0] LSS_LINE_MAX = 10'h3FF;

    // Configuration handed to the split-screen fetch selector
    typedef struct packed {
        logic [16:0] s1_start;
        logic [16:0] s2_start;
        logic [9:0] s1_lines;
        logic [9:0] panel_lines;
        logic portrait;
    } lss_cfg_type;

    // Fetch source for the current display line
    typedef struct packed {
        logic second;
        logic word_addr;
        logic [16:0] base;
    } lss_fetch_type;

    // Address decode, used for every register
    function automatic logic lss_hit(input logic [7:0] a,
                                     input logic [7:0] off);
        return a == off;
    endfunction

endpackage

`default_nettype wire

// >>> design/lss_power_seq.sv
// Panel power and panel logic sequencer around power save.
// Assumes frame_start is a one-cycle pulse on clk, sleep already decoded.
`default_nettype none

module lss_power_seq (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Frame timing
    input wire logic frame_start,
    // Control
    input wire logic sleep,
    input wire logic override,
    // Panel side
    output logic panel_power_en,
    output logic panel_logic_en
);
    import lss_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic power;        // Panel supply enable
        logic logic_on;     // Panel logic signals running
        logic [7:0] cnt;    // Frames spent in power save
    } lss_pwr_type;

    lss_pwr_type q, d;

    // Next state
    always_comb begin
        d = q;
        if (!sleep) begin
            // Logic restarts at once, ahead of power
            d.logic_on = 1'b1;
            d.cnt = '0;
        end else if (frame_start && q.cnt != LSS_DISCHARGE_FRAMES) begin
            // Keep driving while the supply discharges
            d.cnt = q.cnt + 8'h01;
            if (d.cnt == LSS_DISCHARGE_FRAMES) begin
                d.logic_on = 1'b0;
            end
        end
        // Power follows at the next frame start; needs logic already up
        if (frame_start) begin
            d.power = !sleep && !override && q.logic_on;
        end
    end

    // Registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{power: 1'b0, logic_on: 1'b0,
                   cnt: LSS_DISCHARGE_FRAMES};
        end else begin
            q <= d;
        end
    end

    assign panel_power_en = q.power;
    assign panel_logic_en = q.logic_on;

endmodule

`default_nettype wire

// >>> design/lss_split_sel.sv
// Split-screen fetch source selection per display line.
// Assumes frame_start marks line 0 and line_start each later line.
`default_nettype none

module lss_split_sel (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Refresh timing
    input wire logic frame_start,
    input wire logic line_start,
    // Live configuration
    input wire lss_pkg::lss_cfg_type cfg,
    // Fetch source
    output lss_pkg::lss_fetch_type fetch
);
    import lss_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        lss_cfg_type cfg;      // Frame copy of configuration
        logic [9:0] line;      // Line within the frame
        lss_fetch_type fetch;  // Registered fetch source
    } lss_sel_type;

    lss_sel_type q, d;

    // Next state
    always_comb begin
        d = q;
        if (frame_start) begin
            // Mid-frame writes wait for the next frame
            d.cfg = cfg;
            d.line = '0;
        end else if (line_start && q.line != LSS_LINE_MAX) begin
            d.line = q.line + 10'h001;
        end
        // Fetch source moves only on a strobe, never out of reset
        if (frame_start || line_start) begin
            // Screen one on top, screen two after its lines
            d.fetch.second = !d.cfg.portrait
                && d.cfg.s1_lines < d.cfg.panel_lines
                && d.line >= d.cfg.s1_lines;
            d.fetch.base = d.fetch.second ? d.cfg.s2_start
                                          : d.cfg.s1_start;
            // Landscape offsets count words, portrait bytes
            d.fetch.word_addr = !d.cfg.portrait;
        end
    end

    // Registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign fetch = q.fetch;

endmodule

`default_nettype wire

// >>> design/lss_top.sv
// Split-screen refresh control and panel power sequencing, top level.
// Assumes a byte register port and same-clock refresh timing pulses;
// the sleep pin is asynchronous and is synchronised here.
//
// Operation
// - Two bytes form 10-bit screen-one line count.
// - Count at or over panel lines: no split.
// - Frame top fetches from screen-one start; a zero count fetches screen two from line 0.
// - Remaining lines fetch from screen-two start.
// - Screen one always on top.
// - Screen-two start is 17 bits over registers.
// - Screen two starts at next line's left.
// - Landscape start address is a word offset.
// - Portrait disables the split entirely.
// - Power save drops panel power next frame.
// - Logic runs 128 frames after power save.
// - Override updates power next frame, holds off.
// - Pin sleep honoured only when enabled.
// - Power save field: 11 normal, 00 save.
// - Logic active no later than panel power.
// - Screen-one start is 17 bits, top-left.
// - Portrait enable bit in portrait register.
// - Pin low leaves hardware power save.
`default_nettype none

module lss_top (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Refresh timing
    input wire logic frame_start,
    input wire logic line_start,
    // Hardware sleep pin
    input wire logic hw_sleep_request_pin,
    // Panel power
    output logic panel_power_en,
    output logic panel_logic_en,
    // Fetch source
    output lss_pkg::lss_fetch_type fetch
);
    import lss_pkg::*;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------

    // Two-stage release keeps the deassertion synchronous
    logic [1:0] rst_sync_q;
    logic rst_n;

    // Reset synchroniser
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    // Internal reset
    assign rst_n = rst_sync_q[1];

    // ----------------------------------------
    // State
    // ----------------------------------------

    // Software-visible registers and port state
    typedef struct packed {
        logic [1:0] pin_sync;      // Sleep pin synchroniser
        logic override;            // Panel power override
        logic hw_en;               // Hardware save enable
        logic [1:0] swps;          // Software power save field
        logic [7:0] s1_lo;         // Screen-one start bits 7:0
        logic [7:0] s1_mid;        // Screen-one start bits 15:8
        logic s1_b16;              // Screen-one start bit 16
        logic [7:0] s2_lo;         // Screen-two start bits 7:0
        logic [7:0] s2_mid;        // Screen-two start bits 15:8
        logic s2_b16;              // Screen-two start bit 16
        logic [7:0] lines_lo;      // Screen-one lines 7:0
        logic [1:0] lines_hi;      // Screen-one lines 9:8
        logic portrait;            // Portrait enable
        logic [7:0] panel_lo;      // Panel lines 7:0
        logic [1:0] panel_hi;      // Panel lines 9:8
        logic [7:0] rdata;         // Read data, one cycle late
    } lss_top_type;

    lss_top_type q, d;

    // Sub-block connections
    lss_cfg_type cfg;      // Live split configuration
    logic sw_save;         // Software save requested
    logic hw_save;         // Hardware save requested
    logic sleep;           // Either save mode
    logic [7:0] status;    // Read-only status byte

    // ----------------------------------------
    // Power save decode
    // ----------------------------------------

    // Anything but the normal code counts as save; only the two
    // documented codes should be written
    assign sw_save = q.swps != LSS_SWPS_NORMAL;

    // Pin high requests save, only while enabled
    assign hw_save = q.hw_en && q.pin_sync[1];

    // Either mode starts the sequence
    assign sleep = sw_save || hw_save;

    // ----------------------------------------
    // Configuration assembly
    // ----------------------------------------

    // Screen-one start, three registers
    assign cfg.s1_start = {q.s1_b16, q.s1_mid, q.s1_lo};

    // Screen-two start, three registers
    assign cfg.s2_start = {q.s2_b16, q.s2_mid, q.s2_lo};

    // Upper byte gives only two bits
    assign cfg.s1_lines = {q.lines_hi, q.lines_lo};

    // Physical lines of the panel
    assign cfg.panel_lines = {q.panel_hi, q.panel_lo};

    // Portrait switches the split off
    assign cfg.portrait = q.portrait;

    // Status: save request, fetch source and panel state
    assign status = {4'h0, sleep, fetch.second,
                     panel_logic_en, panel_power_en};

    // ----------------------------------------
    // Register file next state
    // ----------------------------------------

    // Writes, reads and the pin synchroniser
    always_comb begin
        d = q;
        // First flop feeds only the second
        d.pin_sync = {q.pin_sync[0], hw_sleep_request_pin};
        // Read data stands for one cycle only
        d.rdata = LSS_RST_BYTE;

        if (reg_wr) begin
            // Mode register: override, enable, save field
            if (lss_hit(reg_addr, LSS_OFF_MODE2)) begin
                d.override = reg_wdata[LSS_BIT_OVERRIDE];
                d.hw_en = reg_wdata[LSS_BIT_HW_EN];
                d.swps = reg_wdata[1:0];
            end
            // Screen-one start bytes
            if (lss_hit(reg_addr, LSS_OFF_S1_LO)) begin
                d.s1_lo = reg_wdata;
            end
            if (lss_hit(reg_addr, LSS_OFF_S1_MID)) begin
                d.s1_mid = reg_wdata;
            end
            // Screen-two start bytes
            if (lss_hit(reg_addr, LSS_OFF_S2_LO)) begin
                d.s2_lo = reg_wdata;
            end
            if (lss_hit(reg_addr, LSS_OFF_S2_MID)) begin
                d.s2_mid = reg_wdata;
            end
            // Bit 16 of both start addresses
            if (lss_hit(reg_addr, LSS_OFF_HI_BITS)) begin
                d.s1_b16 = reg_wdata[LSS_BIT_S1_B16];
                d.s2_b16 = reg_wdata[LSS_BIT_S2_B16];
            end
            // Screen-one line count
            if (lss_hit(reg_addr, LSS_OFF_LINES_LO)) begin
                d.lines_lo = reg_wdata;
            end
            if (lss_hit(reg_addr, LSS_OFF_LINES_HI)) begin
                d.lines_hi = reg_wdata[1:0];
            end
            // Portrait control
            if (lss_hit(reg_addr, LSS_OFF_PORTRAIT)) begin
                d.portrait = reg_wdata[LSS_BIT_PORTRAIT];
            end
            // Panel height
            if (lss_hit(reg_addr, LSS_OFF_PANEL_LO)) begin
                d.panel_lo = reg_wdata;
            end
            if (lss_hit(reg_addr, LSS_OFF_PANEL_HI)) begin
                d.panel_hi = reg_wdata[1:0];
            end
        end

        if (reg_rd) begin
            // Unmapped and reserved bits read as zero
            unique case (1'b1)
                lss_hit(reg_addr, LSS_OFF_MODE2): begin
                    d.rdata[LSS_BIT_OVERRIDE] = q.override;
                    d.rdata[LSS_BIT_HW_EN] = q.hw_en;
                    d.rdata[1:0] = q.swps;
                end
                lss_hit(reg_addr, LSS_OFF_S1_LO): begin
                    d.rdata = q.s1_lo;
                end
                lss_hit(reg_addr, LSS_OFF_S1_MID): begin
                    d.rdata = q.s1_mid;
                end
                lss_hit(reg_addr, LSS_OFF_S2_LO): begin
                    d.rdata = q.s2_lo;
                end
                lss_hit(reg_addr, LSS_OFF_S2_MID): begin
                    d.rdata = q.s2_mid;
                end
                lss_hit(reg_addr, LSS_OFF_HI_BITS): begin
                    d.rdata[LSS_BIT_S1_B16] = q.s1_b16;
                    d.rdata[LSS_BIT_S2_B16] = q.s2_b16;
                end
                lss_hit(reg_addr, LSS_OFF_LINES_LO): begin
                    d.rdata = q.lines_lo;
                end
                lss_hit(reg_addr, LSS_OFF_LINES_HI): begin
                    d.rdata[1:0] = q.lines_hi;
                end
                lss_hit(reg_addr, LSS_OFF_PORTRAIT): begin
                    d.rdata[LSS_BIT_PORTRAIT] = q.portrait;
                end
                lss_hit(reg_addr, LSS_OFF_PANEL_LO): begin
                    d.rdata = q.panel_lo;
                end
                lss_hit(reg_addr, LSS_OFF_PANEL_HI): begin
                    d.rdata[1:0] = q.panel_hi;
                end
                lss_hit(reg_addr, LSS_OFF_STATUS): begin
                    d.rdata = status;
                end
                default: begin
                    // Unmapped address answers zero
                    d.rdata = LSS_RST_BYTE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Register file flops
    // ----------------------------------------

    // Reset leaves the panel in software power save
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.swps <= LSS_SWPS_SAVE;
        end else begin
            q <= d;
        end
    end

    // Read data straight from its flop
    assign reg_rdata = q.rdata;

    // ----------------------------------------
    // Sub-blocks
    // ----------------------------------------

    // Line-by-line fetch source
    lss_split_sel u_split (
        .clk(clk),
        .rst_n(rst_n),
        .frame_start(frame_start),
        .line_start(line_start),
        .cfg(cfg),
        .fetch(fetch)
    );

    // Panel power and logic sequencing; the host keeps the
    // override ordering for manual sequences
    lss_power_seq u_power (
        .clk(clk),
        .rst_n(rst_n),
        .frame_start(frame_start),
        .sleep(sleep),
        .override(q.override),
        .panel_power_en(panel_power_en),
        .panel_logic_en(panel_logic_en)
    );

endmodule

`default_nettype wire

// >>> dv/lss_checker.sv
// Assertion checker for the split-screen and panel power top level.
// Assumes it is bound into lss_top and sees only that module's ports.
`default_nettype none

module lss_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Refresh timing and panel
    input wire logic frame_start,
    input wire logic line_start,
    input wire logic panel_power_en,
    input wire logic panel_logic_en,
    input wire lss_pkg::lss_fetch_type fetch
);
    timeunit 1ns;
    timeprecision 1ps;
    import lss_pkg::*;

    // ----------------------------------------
    // Register shadows
    // ----------------------------------------
    logic [1:0] swps_q; // Power save field
    logic ovr_q; // Power override bit
    logic [7:0] lines_lo_q; // Line count, low byte
    logic portrait_q; // Portrait enable as written
    logic pframe_q; // Portrait enable taken for this frame

    // Only the bits that the properties tie outputs to
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            swps_q <= 2'h0;
            ovr_q <= 1'b0;
            lines_lo_q <= 8'h00;
            portrait_q <= 1'b0;
            pframe_q <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == LSS_OFF_MODE2) begin
                swps_q <= reg_wdata[1:0];
                ovr_q <= reg_wdata[LSS_BIT_OVERRIDE];
            end
            if (reg_wr && reg_addr == LSS_OFF_LINES_LO) begin
                lines_lo_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == LSS_OFF_PORTRAIT) begin
                portrait_q <= reg_wdata[LSS_BIT_PORTRAIT];
            end
            // Old value on purpose: a write at the frame edge waits
            if (frame_start) begin
                pframe_q <= portrait_q;
            end
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_power_needs_logic: assert property (
        panel_power_en |-> panel_logic_en)
        else $error("panel power on while panel logic is off");
    a_power_at_frame: assert property (
        $changed(panel_power_en) |-> $past(frame_start))
        else $error("panel power moved away from a frame start");
    a_override_off: assert property (
        frame_start && ovr_q |=> !panel_power_en [*2])
        else $error("panel power on while override set");
    a_save_drops_power: assert property (
        frame_start && swps_q != LSS_SWPS_NORMAL |=> !panel_power_en)
        else $error("panel power on in software power save");
    a_logic_off_frame: assert property (
        $fell(panel_logic_en) |-> $past(frame_start))
        else $error("panel logic stopped away from a frame start");
    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read reply");
    a_lines_readback: assert property (
        reg_rd && reg_addr == LSS_OFF_LINES_LO |=> reg_rdata == lines_lo_q)
        else $error("line count low byte read back wrong");
    a_portrait_nosplit: assert property (
        pframe_q |-> !fetch.second && !fetch.word_addr)
        else $error("screen two or word offset used in portrait");
    a_fetch_steady: assert property (
        !frame_start && !line_start |=> $stable(fetch))
        else $error("fetch source moved without a line start");
endmodule

bind lss_top lss_checker u_chk (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frame_start(frame_start), .line_start(line_start),
    .panel_power_en(panel_power_en), .panel_logic_en(panel_logic_en),
    .fetch(fetch)
);

`default_nettype wire

// >>> dv/lss_panel_model.sv
// Panel and panel supply seen from the power pins.
// Assumes frame_start is the refresh pulse that the panel also sees.
`default_nettype none

module lss_panel_model (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Panel pins
    input wire logic frame_start,
    input wire logic panel_power_en,
    input wire logic panel_logic_en,
    // Observations
    output logic seq_bad,
    output logic [7:0] discharge_frames
);
    timeunit 1ns;
    timeprecision 1ps;
    // Supply on while the logic is dead can damage the glass
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            seq_bad <= 1'b0;
            discharge_frames <= 8'h00;
        end else begin
            if (panel_power_en && !panel_logic_en) begin
                seq_bad <= 1'b1;
            end
            // Frames the supply gets to discharge with logic running
            if (panel_power_en) begin
                discharge_frames <= 8'h00;
            end else if (frame_start && panel_logic_en) begin
                discharge_frames <= discharge_frames + 8'h01;
            end
        end
    end
endmodule

`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the split-screen and panel power top level.
// Assumes lss_top, the panel model and the bound checker are compiled.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import lss_pkg::*;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk, nrst, reg_wr, reg_rd, frame_start, line_start, pin;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, dis;
    logic pwr, lgc, bad; // Panel pins and model flag
    lss_fetch_type fetch; // Fetch source
    int err_total, checks_done;
    localparam logic [16:0] B1 = 17'h1_0C80; // Screen one start
    localparam logic [16:0] B2 = 17'h1_0040; // Screen two, lower

    lss_top u_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .frame_start(frame_start),
        .line_start(line_start), .hw_sleep_request_pin(pin),
        .panel_power_en(pwr), .panel_logic_en(lgc), .fetch(fetch));
    lss_panel_model u_panel (.clk(clk), .nrst(nrst),
        .frame_start(frame_start), .panel_power_en(pwr),
        .panel_logic_en(lgc), .seq_bad(bad), .discharge_frames(dis));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [18:0] got, input logic [18:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        check({18'h0_0000, got}, {18'h0_0000, exp});
    endtask
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // One write cycle; the strobe drops before the next call
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check({11'h000, reg_rdata}, {11'h000, exp});
    endtask
    // A frame of n lines; line split is the first on screen two
    task automatic frame(input int n, input int split,
                         input logic word, input logic chk);
        lss_fetch_type exp;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            if (i == 0) frame_start <= 1'b1;
            else line_start <= 1'b1;
            @(posedge clk);
            frame_start <= 1'b0;
            line_start <= 1'b0;
            @(negedge clk);
            exp.second = (i >= split);
            exp.word_addr = word;
            exp.base = exp.second ? B2 : B1;
            if (chk) check(fetch, exp);
        end
    endtask
    task automatic pframes(input int k);
        repeat (k) frame(4, 4, 1'b1, 1'b0);
    endtask

    // ----------------------------------------
    // Clock, watchdog and test sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run is near 1200 cycles; this leaves ample margin
    initial begin
        #100_000;
        err_total++;
        end_of_test();
    end
    initial begin
        {nrst, reg_wr, reg_rd, frame_start, line_start, pin} = 6'h00;
        {reg_addr, reg_wdata} = 16'h0000;
        err_total = 0;
        checks_done = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        // Reset state and register widths
        rd(LSS_OFF_MODE2, 8'h00);
        rd(LSS_OFF_LINES_LO, 8'h00);
        chk1(lgc, 1'b0);
        wr(LSS_OFF_LINES_HI, 8'hFF);
        rd(LSS_OFF_LINES_HI, 8'h03);
        wr(8'h40, 8'h5A);
        rd(8'h40, 8'h00);
        // Split: screen two lies lower in memory, still shown below
        wr(LSS_OFF_S1_LO, 8'h80);
        wr(LSS_OFF_S1_MID, 8'h0C);
        wr(LSS_OFF_HI_BITS, 8'h03);
        wr(LSS_OFF_S2_LO, 8'h40);
        wr(LSS_OFF_S2_MID, 8'h00);
        rd(LSS_OFF_S2_LO, 8'h40);
        wr(LSS_OFF_PANEL_LO, 8'h04);
        wr(LSS_OFF_LINES_HI, 8'h00);
        wr(LSS_OFF_LINES_LO, 8'h02);
        rd(LSS_OFF_LINES_LO, 8'h02);
        frame(4, 2, 1'b1, 1'b1);
        // Count equal to, then above, the panel: no split
        wr(LSS_OFF_LINES_LO, 8'h04);
        frame(4, 4, 1'b1, 1'b1);
        wr(LSS_OFF_LINES_HI, 8'h01);
        frame(4, 4, 1'b1, 1'b1);
        wr(LSS_OFF_LINES_HI, 8'h00);
        wr(LSS_OFF_LINES_LO, 8'h02);
        // Mid-frame write waits for the next frame
        fork
            frame(4, 2, 1'b1, 1'b1);
            begin
                repeat (3) @(posedge clk);
                wr(LSS_OFF_LINES_LO, 8'h00);
            end
        join
        frame(4, 0, 1'b1, 1'b1);
        wr(LSS_OFF_PORTRAIT, 8'h80);
        frame(4, 4, 1'b0, 1'b1);
        wr(LSS_OFF_PORTRAIT, 8'h00);
        // Wake, then automatic power-down
        wr(LSS_OFF_MODE2, 8'h03);
        pframes(1);
        chk1(pwr, 1'b1);
        rd(LSS_OFF_STATUS, 8'h07);
        wr(LSS_OFF_MODE2, 8'h00);
        pframes(1);
        chk1(pwr, 1'b0);
        pframes(126);
        chk1(lgc, 1'b1);
        pframes(1);
        chk1(lgc, 1'b0);
        check({11'h000, dis}, 19'h0_007F);
        // Manual power-up: override first, then leave save
        wr(LSS_OFF_MODE2, 8'h08);
        wr(LSS_OFF_MODE2, 8'h0B);
        pframes(2);
        chk1(pwr, 1'b0);
        chk1(lgc, 1'b1);
        wr(LSS_OFF_MODE2, 8'h03);
        pframes(1);
        chk1(pwr, 1'b1);
        // Manual power-down starts with the override
        wr(LSS_OFF_MODE2, 8'h0B);
        pframes(1);
        chk1(pwr, 1'b0);
        wr(LSS_OFF_MODE2, 8'h03);
        pframes(1);
        chk1(pwr, 1'b1);
        // Sleep pin: ignored until enabled, low level wakes
        @(posedge clk);
        pin <= 1'b1;
        pframes(1);
        chk1(pwr, 1'b1);
        wr(LSS_OFF_MODE2, 8'h83);
        pframes(1);
        chk1(pwr, 1'b0);
        @(posedge clk);
        pin <= 1'b0;
        // Synchroniser delay before the frame edge
        repeat (4) @(posedge clk);
        pframes(1);
        chk1(pwr, 1'b1);
        chk1(bad, 1'b0);
        end_of_test();
    end
endmodule

`default_nettype wire
